// File: acal_ctrl.sv
`timescale 1ns/1ps
`include "acal_regs.svh"
// Contract
// - Mode 4 calibrates offset on internal zero.
// - Offset result goes to result register only.
// - Reset reloads factory offset and gain coefficients.
// - Every calibration ends with converters idle.
// - Mode 5 runs two-stage gain calibration.
// - Gain result goes to result register only.
// - Mode 6 zero-scale calibrates from input pins.
// - Mode 7 full-scale calibrates from input pins.
// - Offset coefficient is 24-bit signed, subtracted.
// - Zero offset coefficient removes nothing.
// - Gain scales by coefficient over nominal.
// - Scaled value clamped, then formatted.
// - Offset aligned by 32, rescaled four thirds.
// - Current gain reset value suits gain 8.
// - Chop bit fifteen enables chopping mode.
// - Idle keeps converters powered, held in reset.
// - Starting calibration aborts running conversion.
// - Code 2 single, code 1 continuous.
module acal_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire acal_pkg::acal_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output acal_pkg::acal_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire acal_pkg::acal_word_t filt_cur_data,
   input wire acal_pkg::acal_word_t filt_vol_data,
   input wire logic filt_valid,
   output logic conv_power,
   output logic conv_hold,
   output logic conv_chop,
   output logic [19:0] conv_filter_cfg,
   output logic [1:0] conv_input_sel,
   output logic [1:0] conv_enable,
   output logic conv_temp_sel
);
   import acal_pkg::*;

   // Word match on the upper address bits; byte offsets within a word are ignored.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a[7:2] == r[7:2];
   endfunction : hit

   // Merge a bus write into an old word under the byte strobes.
   function automatic acal_word_t merge(input acal_word_t old, input acal_word_t d, input logic [3:0] s);
      acal_word_t m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Which coefficient set a channel uses; the voltage channel borrows the temperature set when temperature select is set.
   function automatic logic [1:0] coef_idx(input int c, input logic tsel);
      return (c == 1 && tsel) ? 2'h2 : 2'(c);
   endfunction : coef_idx

   // State entered when a mode code is written.
   function automatic acal_state_e start_st(input logic [2:0] m);
      if (m == `ACAL_MD_CONT || m == `ACAL_MD_SNGL) begin
         return ST_CONV;
      end else if (m[2]) begin
         return ST_CAL1;
      end
      return ST_IDLE;
   endfunction : start_st

   logic [2:0] mode_ff; // Converter mode field.
   logic [19:0] filt_ff; // Filter configuration.
   logic [3:0] ctrl_ff; // Enables, temperature select, unipolar.
   logic [1:0] rdy_ff; // Sticky ready flags per channel.
   logic [1:0] ovf_ff; // Sticky clamp flags per channel.
   acal_ofs_t of_ff [3]; // Offset coefficients: current, voltage, temperature.
   acal_gain_t gn_ff [3]; // Gain coefficients in the same order.
   acal_word_t res_ff [2]; // Channel result registers.
   acal_state_e state_ff;
   acal_state_e nxt_state;
   logic restart_ff; // One-cycle filter restart after a mode write or stage switch.
   logic [3:0] cnt_ff; // Divider bit position.
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   acal_word_t rdata_ff;

   // Bus decode. Address and data are taken together, only when no response is pending.
   logic wr_en, rd_en, mode_wr, stat_wr, filt_wr, ctrl_wr;
   acal_word_t rd_word;
   assign wr_en = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign rd_en = s_axi_arvalid & ~rvalid_ff;
   assign s_axi_awready = wr_en;
   assign s_axi_wready = wr_en;
   assign s_axi_arready = rd_en;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign mode_wr = wr_en & hit(s_axi_awaddr, `ACAL_A_MODE) & s_axi_wstrb[0];
   assign stat_wr = wr_en & hit(s_axi_awaddr, `ACAL_A_STAT) & s_axi_wstrb[0];
   assign filt_wr = wr_en & hit(s_axi_awaddr, `ACAL_A_FILT);
   assign ctrl_wr = wr_en & hit(s_axi_awaddr, `ACAL_A_CTRL) & s_axi_wstrb[0];

   // Sequencer events. A sample taken while the filter restarts belongs to the old setup.
   logic smp, conv_done, ofs_done, div_done, cal_done, div_ld, ofs_mode;
   logic [1:0] set_rdy, set_ovf;
   assign smp = filt_valid & ~restart_ff & ~mode_wr;
   assign ofs_mode = (mode_ff == `ACAL_MD_SOFS) | (mode_ff == `ACAL_MD_ZS);
   assign conv_done = (state_ff == ST_CONV) & smp;
   assign ofs_done = (state_ff == ST_CAL1) & smp & ofs_mode;
   assign div_done = (state_ff == ST_DIV) & (cnt_ff == 4'h0) & ~mode_wr;
   assign cal_done = ofs_done | div_done;
   assign div_ld = (nxt_state == ST_DIV) & (state_ff != ST_DIV);

   // Read multiplexer; reserved bits read as zero.
   assign rd_word = hit(s_axi_araddr, `ACAL_A_MODE) ? {29'h0, mode_ff} :
      hit(s_axi_araddr, `ACAL_A_FILT) ? {12'h0, filt_ff} :
      hit(s_axi_araddr, `ACAL_A_STAT) ? {27'h0, state_ff != ST_IDLE, ovf_ff, rdy_ff} :
      hit(s_axi_araddr, `ACAL_A_CTRL) ? {28'h0, ctrl_ff} :
      hit(s_axi_araddr, `ACAL_A_OF0) ? {8'h0, of_ff[0]} :
      hit(s_axi_araddr, `ACAL_A_GN0) ? {16'h0, gn_ff[0]} :
      hit(s_axi_araddr, `ACAL_A_OF1) ? {8'h0, of_ff[1]} :
      hit(s_axi_araddr, `ACAL_A_GN1) ? {16'h0, gn_ff[1]} :
      hit(s_axi_araddr, `ACAL_A_OF2) ? {8'h0, of_ff[2]} :
      hit(s_axi_araddr, `ACAL_A_GN2) ? {16'h0, gn_ff[2]} :
      hit(s_axi_araddr, `ACAL_A_RES0) ? res_ff[0] :
      hit(s_axi_araddr, `ACAL_A_RES1) ? res_ff[1] : 32'h0000_0000;

   // Bus responses; addresses past the last register answer SLVERR.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `ACAL_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= `ACAL_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else begin
         if (wr_en) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (s_axi_awaddr[7:2] > `ACAL_A_RES1 >> 2) ? `ACAL_SLVERR : `ACAL_OKAY;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_en) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= (s_axi_araddr[7:2] > `ACAL_A_RES1 >> 2) ? `ACAL_SLVERR : `ACAL_OKAY;
            rdata_ff <= rd_word;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Next state. A mode write overrides whatever runs, which aborts it.
   always_comb begin
      nxt_state = state_ff;
      if (mode_wr) begin
         nxt_state = start_st(s_axi_wdata[2:0]);
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_CONV: begin
               if (conv_done && mode_ff == `ACAL_MD_SNGL) begin
                  nxt_state = ST_IDLE;
               end
            end
            ST_CAL1: begin
               // Offset modes end here; self gain needs a second stage; full-scale divides.
               if (smp) begin
                  nxt_state = ofs_mode ? ST_IDLE : (mode_ff == `ACAL_MD_SGN) ? ST_CAL2 : ST_DIV;
               end
            end
            ST_CAL2: begin
               if (smp) begin
                  nxt_state = ST_DIV;
               end
            end
            ST_DIV: begin
               if (cnt_ff == 4'h0) begin
                  nxt_state = ST_IDLE;
               end
            end
         endcase
      end
   end

   // Control registers and sequencer. The set of a flag wins over a clear in the same cycle.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_ff <= `ACAL_MD_IDLE;
         filt_ff <= `ACAL_FILT_RST;
         ctrl_ff <= `ACAL_CTRL_RST;
         rdy_ff <= 2'h0;
         ovf_ff <= 2'h0;
         state_ff <= ST_IDLE;
         restart_ff <= 1'b0;
         cnt_ff <= `ACAL_DIV_LAST;
      end else begin
         if (mode_wr) begin
            mode_ff <= s_axi_wdata[2:0];
         end else if (cal_done || (conv_done && mode_ff == `ACAL_MD_SNGL)) begin
            mode_ff <= `ACAL_MD_IDLE;
         end
         if (filt_wr) begin
            filt_ff <= 20'(merge({12'h0, filt_ff}, s_axi_wdata, s_axi_wstrb));
         end
         if (ctrl_wr) begin
            ctrl_ff <= s_axi_wdata[3:0];
         end
         rdy_ff <= set_rdy | (rdy_ff & ~(stat_wr ? s_axi_wdata[1:0] : 2'h0));
         ovf_ff <= set_ovf | (ovf_ff & ~(stat_wr ? s_axi_wdata[3:2] : 2'h0));
         state_ff <= nxt_state;
         // The filter restarts when the mode field is written and before the second gain stage.
         restart_ff <= mode_wr | ((state_ff == ST_CAL1) & smp & (mode_ff == `ACAL_MD_SGN));
         cnt_ff <= div_ld ? `ACAL_DIV_LAST : (state_ff == ST_DIV) ? cnt_ff - 4'h1 : cnt_ff;
      end
   end

   // Converter control outputs. Idle keeps power on but holds the modulator in reset.
   assign conv_power = mode_ff != `ACAL_MD_PDN;
   assign conv_hold = (state_ff == ST_IDLE) | (state_ff == ST_DIV) | restart_ff;
   assign conv_chop = filt_ff[`ACAL_CHOP_BIT];
   assign conv_filter_cfg = filt_ff;
   assign conv_enable = ctrl_ff[1:0];
   assign conv_temp_sel = ctrl_ff[`ACAL_CTL_TSEL];
   assign conv_input_sel = (state_ff == ST_CAL2) ? `ACAL_IN_REF :
      ((state_ff == ST_CAL1) && (mode_ff == `ACAL_MD_SOFS || mode_ff == `ACAL_MD_SGN)) ?
      `ACAL_IN_ZERO : `ACAL_IN_PINS;

   // Coefficient registers. Reset reloads factory values; software stores calibration results.
   for (genvar k = 0; k < 3; k++) begin : g_coef
      localparam logic [7:0] OFA = 8'(`ACAL_A_OF0 + k * `ACAL_COEF_STRIDE);
      localparam logic [7:0] GNA = 8'(`ACAL_A_GN0 + k * `ACAL_COEF_STRIDE);
      acal_word_t of_m, gn_m;
      assign of_m = merge({8'h0, of_ff[k]}, s_axi_wdata, s_axi_wstrb);
      assign gn_m = merge({16'h0, gn_ff[k]}, s_axi_wdata, s_axi_wstrb);
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            of_ff[k] <= `ACAL_OF_FACT;
            gn_ff[k] <= (k == 0) ? `ACAL_GN0_FACT : `ACAL_GN_FACT;
         end else begin
            if (wr_en && hit(s_axi_awaddr, OFA)) begin
               of_ff[k] <= of_m[23:0];
            end
            if (wr_en && hit(s_axi_awaddr, GNA)) begin
               gn_ff[k] <= gn_m[15:0];
            end
         end
      end
   end

   // Per-channel datapath: offset removal, gain scaling, clamp, and calibration arithmetic.
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [1:0] k;
      logic signed [33:0] x, ofs, diff, ocoef, d, zcap_ff;
      logic signed [50:0] prod, scl;
      logic pos_ovf, neg_ovf, uni, sat_w, sat_ff;
      logic [49:0] num, den_w, den_ff, rem_ff, trial;
      logic [15:0] quo_ff;
      logic [15:0] quo_w; // Quotient including the bit decided in the last divide cycle.
      acal_word_t fmt, nxt_res;
      assign k = coef_idx(c, ctrl_ff[`ACAL_CTL_TSEL]);
      assign x = (c == 0) ? $signed({{2{filt_cur_data[31]}}, filt_cur_data}) :
         $signed({{2{filt_vol_data[31]}}, filt_vol_data});
      // The 24-bit offset is widened to result format, then restored from its 0.75 scale.
      assign ofs = (($signed({{10{of_ff[k][23]}}, of_ff[k]}) <<< `ACAL_ALIGN_SH) * `ACAL_RESC_NUM)
         / `ACAL_RESC_DEN;
      assign diff = x - ofs;
      // Exact division by the nominal gain keeps a nominal coefficient a true unity path.
      assign prod = diff * $signed({1'b0, gn_ff[k]});
      assign scl = prod / $signed({35'h0, `ACAL_GN_NOM});
      assign uni = ctrl_ff[`ACAL_CTL_UNI];
      assign pos_ovf = scl > $signed({19'h0, `ACAL_POS_FS});
      assign neg_ovf = scl < $signed({{19{1'b1}}, `ACAL_NEG_FS});
      assign fmt = pos_ovf ? `ACAL_POS_FS : (uni && scl[50]) ? 32'h0000_0000 :
         neg_ovf ? `ACAL_NEG_FS : scl[31:0];
      // Offset coefficient is the inverse of the correction applied above.
      assign ocoef = ((x * `ACAL_RESC_DEN) / `ACAL_RESC_NUM) >>> `ACAL_ALIGN_SH;
      // Gain span: reference minus captured zero, or input minus present offset.
      assign d = (state_ff == ST_CAL2) ? x - zcap_ff : diff;
      assign num = {3'h0, `ACAL_GN_NOM, {`ACAL_FS_SH{1'b0}}};
      assign den_w = {16'h0, d};
      // A span too small for a 16-bit coefficient saturates instead of wrapping.
      assign sat_w = d[33] | (d == 34'sh0_0000_0000) | (num >= (den_w << 16));
      assign trial = den_ff << cnt_ff;
      // The result lands in the last divide cycle, before bit zero is stored, so that bit is taken live.
      assign quo_w = {quo_ff[15:1], rem_ff >= trial};
      assign nxt_res = conv_done ? fmt : ofs_done ? {{8{ocoef[23]}}, ocoef[23:0]} :
         {16'h0, sat_ff ? `ACAL_GN_SAT : quo_w};
      assign set_rdy[c] = ctrl_ff[c] & (conv_done | cal_done);
      assign set_ovf[c] = ctrl_ff[c] & conv_done & (pos_ovf | neg_ovf);
      // Result register and a restoring divider producing one quotient bit per cycle.
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            res_ff[c] <= 32'h0000_0000;
            zcap_ff <= 34'sh0_0000_0000;
            den_ff <= 50'h0;
            rem_ff <= 50'h0;
            quo_ff <= 16'h0000;
            sat_ff <= 1'b0;
         end else begin
            if (set_rdy[c]) begin
               res_ff[c] <= nxt_res;
            end
            if ((state_ff == ST_CAL1) && smp && (mode_ff == `ACAL_MD_SGN)) begin
               zcap_ff <= x;
            end
            if (div_ld) begin
               den_ff <= den_w;
               rem_ff <= num;
               quo_ff <= 16'h0000;
               sat_ff <= sat_w;
            end else if ((state_ff == ST_DIV) && (rem_ff >= trial)) begin
               rem_ff <= rem_ff - trial;
               quo_ff[cnt_ff] <= 1'b1;
            end
         end
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_gn_stage1;
      state_ff == ST_CAL1 && mode_ff == `ACAL_MD_SGN && smp;
   endsequence
   sequence s_gn_stage2;
      restart_ff && state_ff == ST_CAL2 && conv_input_sel == `ACAL_IN_REF;
   endsequence

   a_self_ofs_zero: assert property (state_ff == ST_CAL1 && mode_ff == `ACAL_MD_SOFS |-> conv_input_sel == `ACAL_IN_ZERO)
      else $error("Self offset calibration not on internal zero.");
   a_ofs_result: assert property (ofs_done && ctrl_ff[0] |=> res_ff[0][23:0] == $past(g_ch[0].ocoef[23:0]))
      else $error("Offset coefficient missing from result.");
   a_factory_load: assert property ($past(rst) |-> of_ff[1] == `ACAL_OF_FACT && gn_ff[0] == `ACAL_GN0_FACT)
      else $error("Coefficients not at factory values after reset.");
   a_cal_idle: assert property (cal_done |=> state_ff == ST_IDLE && mode_ff == `ACAL_MD_IDLE && conv_hold)
      else $error("Converters not idle after calibration.");
   a_gain_stages: assert property (s_gn_stage1 |=> s_gn_stage2)
      else $error("Self gain calibration skipped its second stage.");
   a_coef_kept: assert property (cal_done && !wr_en |=> $stable(of_ff[0]) && $stable(gn_ff[0]))
      else $error("Calibration changed a coefficient register.");
   a_zs_pins: assert property (state_ff == ST_CAL1 && mode_ff == `ACAL_MD_ZS |-> conv_input_sel == `ACAL_IN_PINS)
      else $error("Zero-scale calibration not from pins.");
   a_fs_divide: assert property (state_ff == ST_CAL1 && mode_ff == `ACAL_MD_FS && smp
      |=> state_ff == ST_DIV && cnt_ff == `ACAL_DIV_LAST)
      else $error("Full-scale calibration did not start the divider.");
   a_unity_path: assert property (conv_done && ctrl_ff[0] && of_ff[0] == 24'h00_0000 && gn_ff[0] == `ACAL_GN_NOM
      && !ctrl_ff[`ACAL_CTL_UNI] |=> res_ff[0] == $past(filt_cur_data))
      else $error("Nominal coefficients altered the sample.");
   a_chop_write: assert property (filt_wr && s_axi_wstrb[1] |=> conv_chop == $past(s_axi_wdata[15]))
      else $error("Chop output does not follow the filter write.");
   a_idle_hold: assert property (state_ff == ST_IDLE && mode_ff != `ACAL_MD_PDN |-> conv_hold && conv_power)
      else $error("Idle converter not powered and held.");
   a_abort_hold: assert property (mode_wr |=> conv_hold && state_ff == start_st($past(s_axi_wdata[2:0])))
      else $error("Mode write did not restart the converter.");
   a_single_idle: assert property (conv_done && mode_ff == `ACAL_MD_SNGL |=> mode_ff == `ACAL_MD_IDLE)
      else $error("Single conversion did not return to idle.");
   a_cal_ready: assert property (cal_done && ctrl_ff[1] |=> rdy_ff[1])
      else $error("Calibration completion did not set ready.");
endmodule : acal_ctrl

// File: acal_pkg.sv
package acal_pkg;
   // Bus word and coefficient types.
   typedef logic [31:0] acal_word_t;
   typedef logic [23:0] acal_ofs_t;
   typedef logic [15:0] acal_gain_t;
   // Sequencer states, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CONV = 5'h02,
      ST_CAL1 = 5'h04,
      ST_CAL2 = 5'h08,
      ST_DIV = 5'h10
   } acal_state_e;
endpackage : acal_pkg

// File: acal_regs.svh
`ifndef ACAL_REGS_SVH
`define ACAL_REGS_SVH
// Register byte offsets on the AXI4-Lite port.
`define ACAL_A_MODE 8'h00
`define ACAL_A_FILT 8'h04
`define ACAL_A_STAT 8'h08
`define ACAL_A_CTRL 8'h0C
`define ACAL_A_OF0 8'h10
`define ACAL_A_GN0 8'h14
`define ACAL_A_OF1 8'h18
`define ACAL_A_GN1 8'h1C
`define ACAL_A_OF2 8'h20
`define ACAL_A_GN2 8'h24
`define ACAL_A_RES0 8'h28
`define ACAL_A_RES1 8'h2C
`define ACAL_COEF_STRIDE 8'h08
// Codes of the converter mode field.
`define ACAL_MD_PDN 3'h0
`define ACAL_MD_CONT 3'h1
`define ACAL_MD_SNGL 3'h2
`define ACAL_MD_IDLE 3'h3
`define ACAL_MD_SOFS 3'h4
`define ACAL_MD_SGN 3'h5
`define ACAL_MD_ZS 3'h6
`define ACAL_MD_FS 3'h7
// Converter input selection codes.
`define ACAL_IN_PINS 2'h0
`define ACAL_IN_ZERO 2'h1
`define ACAL_IN_REF 2'h2
// Field positions.
`define ACAL_CHOP_BIT 15
`define ACAL_CTL_TSEL 2
`define ACAL_CTL_UNI 3
// Reset and factory values.
`define ACAL_FILT_RST 20'h0_0007
`define ACAL_CTRL_RST 4'h3
`define ACAL_OF_FACT 24'h00_0000
`define ACAL_GN_FACT 16'h5555
`define ACAL_GN0_FACT 16'h5555
// Arithmetic constants.
`define ACAL_GN_NOM 16'h5555
`define ACAL_GN_SAT 16'hFFFF
`define ACAL_ALIGN_SH 5
`define ACAL_RESC_NUM 34'sh0_0000_0004
`define ACAL_RESC_DEN 34'sh0_0000_0003
`define ACAL_FS_SH 31
`define ACAL_POS_FS 32'h7FFF_FFFF
`define ACAL_NEG_FS 32'h8000_0000
`define ACAL_DIV_LAST 4'hF
`define ACAL_OKAY 2'h0
`define ACAL_SLVERR 2'h2
`endif

// File: adc_calibration_control_tb.sv
`timescale 1ns/1ps
`include "acal_regs.svh"
// Register-level bench: every test is a sequence of bus calls and filter samples with expected values.
module adc_calibration_control_tb;
   import acal_pkg::*;
   logic ref_clk = 1'h0; // Free-running 25 MHz clock.
   logic rst = 1'h1; // Held for eight cycles at the start.
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, filt_valid = 1'h0;
   logic [3:0] s_axi_wstrb = 4'hF; // Full words only; strobes are not the subject here.
   acal_word_t s_axi_wdata = '0, filt_cur_data = '0, filt_vol_data = '0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic conv_power, conv_hold, conv_chop, conv_temp_sel;
   logic [1:0] s_axi_bresp, s_axi_rresp, conv_input_sel, conv_enable;
   logic [19:0] conv_filter_cfg;
   int num_errors = 0;
   int num_checks = 0;
   // The device under test, every port tied to the bench signal of the same name.
   acal_ctrl u_acal_ctrl (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filt_cur_data,
      .filt_vol_data, .filt_valid, .conv_power, .conv_hold, .conv_chop, .conv_filter_cfg, .conv_input_sel,
      .conv_enable, .conv_temp_sel);
   // Clock generator.
   initial forever #20 ref_clk = ~ref_clk;
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // Case-equality compare, so an unknown never passes.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // A wait that ran out of cycles counts as a mismatch and closes the run.
   task automatic lim(input int n);
      if (n >= 50) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, n, 0);
         tally_and_finish();
      end
   endtask : lim
   // Bus write: address and data offered together, response checked against the expected code.
   task automatic wr(input logic [7:0] a, input acal_word_t d, input logic [1:0] rsp = `ACAL_OKAY);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin @(posedge ref_clk); n++; end while (!(s_axi_awready === 1'h1 && s_axi_wready === 1'h1) && n < 50);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do begin @(posedge ref_clk); n++; end while (s_axi_bvalid !== 1'h1 && n < 50);
      s_axi_bready <= 1'h0;
      lim(n);
      chk({30'h0, s_axi_bresp}, {30'h0, rsp});
   endtask : wr
   // Bus read with the expected word compared at the edge that takes the answer.
   task automatic rd(input logic [7:0] a, input acal_word_t exp, input logic [1:0] rsp = `ACAL_OKAY);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin @(posedge ref_clk); n++; end while (s_axi_arready !== 1'h1 && n < 50);
      s_axi_arvalid <= 1'h0;
      do begin @(posedge ref_clk); n++; end while (s_axi_rvalid !== 1'h1 && n < 50);
      s_axi_rready <= 1'h0;
      lim(n);
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, rsp});
   endtask : rd
   // One settled filter sample on both channels, then two quiet cycles for the result to land.
   task automatic smp(input acal_word_t c, input acal_word_t v);
      @(posedge ref_clk);
      filt_cur_data <= c;
      filt_vol_data <= v;
      filt_valid <= 1'h1;
      @(posedge ref_clk);
      filt_valid <= 1'h0;
      repeat (2) @(posedge ref_clk);
   endtask : smp
   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      rd(`ACAL_A_MODE, 32'h0000_0003);
      rd(`ACAL_A_FILT, 32'h0000_0007);
      rd(`ACAL_A_OF0, 32'h0000_0000);
      rd(`ACAL_A_GN0, 32'h0000_5555);
      chk({30'h0, conv_hold, conv_power}, 32'h0000_0003);
      // Samples offered while idle must not produce a result.
      smp(32'h0000_0100, 32'h0000_0100);
      rd(`ACAL_A_RES0, 32'h0000_0000);
      // Internal offset calibration, positive on current and negative on voltage.
      wr(`ACAL_A_FILT, 32'h0000_007F);
      wr(`ACAL_A_MODE, 32'h0000_0004);
      chk({30'h0, conv_input_sel}, 32'h0000_0001);
      smp(32'h0000_0400, 32'hFFFF_FC00);
      rd(`ACAL_A_RES0, 32'h0000_0018);
      rd(`ACAL_A_RES1, 32'hFFFF_FFE8);
      rd(`ACAL_A_OF0, 32'h0000_0000);
      rd(`ACAL_A_MODE, 32'h0000_0003);
      rd(`ACAL_A_STAT, 32'h0000_0003);
      chk({31'h0, conv_hold}, 32'h0000_0001);
      // System zero-scale calibration reads the pins.
      wr(`ACAL_A_STAT, 32'h0000_000F);
      wr(`ACAL_A_MODE, 32'h0000_0006);
      chk({30'h0, conv_input_sel}, 32'h0000_0000);
      smp(32'h0000_0800, 32'h0000_0800);
      rd(`ACAL_A_RES0, 32'h0000_0030);
      // Single conversion with offset three (128 after alignment and rescaling) and doubled gain on current only.
      wr(`ACAL_A_OF0, 32'h0000_0003);
      wr(`ACAL_A_GN0, 32'h0000_AAAA);
      wr(`ACAL_A_MODE, 32'h0000_0002);
      smp(32'h0000_1000, 32'h0000_1000);
      rd(`ACAL_A_RES0, 32'h0000_1F00);
      rd(`ACAL_A_RES1, 32'h0000_1000);
      rd(`ACAL_A_MODE, 32'h0000_0003);
      // Continuous mode: an overflow clamps, then a second sample still updates.
      wr(`ACAL_A_MODE, 32'h0000_0001);
      smp(32'h7000_0000, 32'h0000_0000);
      rd(`ACAL_A_RES0, 32'h7FFF_FFFF);
      smp(32'h0000_2000, 32'h0000_0000);
      rd(`ACAL_A_RES0, 32'h0000_3F00);
      rd(`ACAL_A_MODE, 32'h0000_0001);
      // A reset in mid-run restores the factory coefficients.
      rst <= 1'h1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      rd(`ACAL_A_OF0, 32'h0000_0000);
      rd(`ACAL_A_GN0, 32'h0000_5555);
      // Self gain: zero then reference; a span of 2^30 gives twice the nominal coefficient.
      wr(`ACAL_A_MODE, 32'h0000_0005);
      smp(32'h0000_0000, 32'h0000_0000);
      chk({30'h0, conv_input_sel}, 32'h0000_0002);
      smp(32'h4000_0000, 32'h4000_0000);
      repeat (20) @(posedge ref_clk);
      rd(`ACAL_A_RES0, 32'h0000_AAAA);
      rd(`ACAL_A_RES1, 32'h0000_AAAA);
      rd(`ACAL_A_GN0, 32'h0000_5555);
      // System full-scale: span 3*2^29 gives four thirds of nominal, truncated.
      wr(`ACAL_A_MODE, 32'h0000_0007);
      smp(32'h6000_0000, 32'h6000_0000);
      repeat (20) @(posedge ref_clk);
      rd(`ACAL_A_RES0, 32'h0000_71C6);
      rd(`ACAL_A_MODE, 32'h0000_0003);
      // The widest span gives an odd coefficient, so the last quotient bit is seen.
      wr(`ACAL_A_MODE, 32'h0000_0007);
      smp(32'h7FFF_FFFF, 32'h7FFF_FFFF);
      repeat (20) @(posedge ref_clk);
      rd(`ACAL_A_RES0, 32'h0000_5555);
      // Voltage on temperature coefficients, nominal current path, then unipolar clamp.
      wr(`ACAL_A_OF2, 32'h0000_0003);
      wr(`ACAL_A_CTRL, 32'h0000_0007);
      chk({29'h0, conv_temp_sel, conv_enable}, 32'h0000_0007);
      wr(`ACAL_A_MODE, 32'h0000_0001);
      smp(32'hFFFF_F000, 32'h0000_1000);
      rd(`ACAL_A_RES0, 32'hFFFF_F000);
      rd(`ACAL_A_RES1, 32'h0000_0F80);
      wr(`ACAL_A_CTRL, 32'h0000_000F);
      smp(32'hFFFF_F000, 32'h0000_1000);
      rd(`ACAL_A_RES0, 32'h0000_0000);
      // Chop bit and filter configuration reach the converter.
      wr(`ACAL_A_FILT, 32'h0000_8007);
      chk({31'h0, conv_chop}, 32'h0000_0001);
      chk({12'h0, conv_filter_cfg}, 32'h0000_8007);
      // Power-down drops converter power while the sequencer stays idle.
      wr(`ACAL_A_MODE, 32'h0000_0000);
      chk({30'h0, conv_hold, conv_power}, 32'h0000_0002);
      wr(8'h30, 32'h0000_0000, `ACAL_SLVERR);
      rd(8'h30, 32'h0000_0000, `ACAL_SLVERR);
      tally_and_finish();
   end
endmodule : adc_calibration_control_tb
